// ---- hdl/urd_top.sv ----
// Register map and offset decoder for one serial port channel.
// Assumes a front end that turns bus cycles into single-cycle requests.
`timescale 1ns/100ps
`default_nettype none
module urd_top
    import urd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire urd_req_t req,
    input wire urd_stat_t stat,
    output urd_cfg_t cfg,
    output logic [7:0] rdata,
    output logic rvalid,
    output urd_evt_t evt
);
    // ****************************************
    // Decode
    // ****************************************
    urd_cfg_t st_r;
    urd_cfg_t st_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    urd_evt_t evt_r;
    urd_evt_t evt_nxt;
    urd_sel_t sel;
    logic key_bank;
    logic div_bank;
    logic enh_on;
    logic lvl_bank;

    assign key_bank = (st_r.line_ctl == ENH_BANK_KEY);
    assign div_bank = st_r.line_ctl.div_en;
    assign enh_on = st_r.enh_fn.enh_en;
    assign lvl_bank = st_r.modem_ctl.internal_output_one;

    // Keeps old bits where the mask is clear
    function automatic logic [7:0] merge(
        input logic [7:0] old_v,
        input logic [7:0] new_v,
        input logic [7:0] keep_new
    );
        merge = (new_v & keep_new) | (old_v & ~keep_new);
    endfunction

    always_comb begin
        sel = SEL_NONE;
        case (req.addr)
            OFS_HOLD: begin
                if (div_bank) begin
                    sel = SEL_DIV_LO;
                end else begin
                    sel = SEL_HOLD;
                end
            end
            OFS_INT_EN: begin
                if (div_bank) begin
                    sel = SEL_DIV_HI;
                end else begin
                    sel = SEL_INT_EN;
                end
            end
            OFS_FIFO: begin
                if (key_bank) begin
                    sel = SEL_ENH_FN;
                end else if (div_bank) begin
                    // Without enhanced mode nothing answers here
                    sel = enh_on ? SEL_DIV_FRAC : SEL_NONE;
                end else begin
                    sel = SEL_FIFO;
                end
            end
            OFS_LINE_CTL: begin
                sel = SEL_LINE_CTL;
            end
            OFS_MODEM_CTL: begin
                sel = key_bank ? SEL_RESUME_ONE : SEL_MODEM_CTL;
            end
            OFS_LINE_STAT: begin
                sel = key_bank ? SEL_RESUME_TWO : SEL_LINE_STAT;
            end
            OFS_MODEM_STAT: begin
                if (key_bank) begin
                    sel = SEL_STOP_ONE;
                end else if (lvl_bank) begin
                    sel = SEL_HALT;
                end else begin
                    sel = SEL_MODEM_STAT;
                end
            end
            OFS_SCRATCH: begin
                if (key_bank) begin
                    sel = SEL_STOP_TWO;
                end else if (lvl_bank) begin
                    sel = SEL_TRIG;
                end else begin
                    sel = SEL_SCRATCH;
                end
            end
            OFS_TX_FILL: begin
                sel = SEL_TX_FILL;
            end
            OFS_RX_FILL: begin
                sel = SEL_RX_FILL;
            end
            OFS_PIN_DIR: begin
                sel = SEL_PIN_DIR;
            end
            OFS_PIN_STATE: begin
                sel = SEL_PIN_STATE;
            end
            OFS_PIN_IE: begin
                sel = SEL_PIN_IE;
            end
            OFS_RSVD: begin
                sel = SEL_RSVD;
            end
            OFS_PIN_CTL: begin
                sel = SEL_PIN_CTL;
            end
            OFS_EXTRA: begin
                sel = SEL_EXTRA;
            end
            default: begin
                sel = SEL_NONE;
            end
        endcase
    end

    // ****************************************
    // Register writes
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        if (req.wr) begin
            case (sel)
                SEL_DIV_LO: begin
                    st_nxt.div_lo = req.wdata;
                end
                SEL_DIV_HI: begin
                    st_nxt.div_hi = req.wdata;
                end
                SEL_DIV_FRAC: begin
                    st_nxt.div_frac = req.wdata;
                end
                SEL_INT_EN: begin
                    st_nxt.int_en = urd_int_en_t'(merge(st_r.int_en, req.wdata,
                        enh_on ? 8'hff : ~INT_EN_ENH_MASK));
                end
                SEL_FIFO: begin
                    st_nxt.fifo.en = req.wdata[FIFO_EN_BIT];
                    st_nxt.fifo.rx_trig = req.wdata[7:6];
                    if (enh_on) begin
                        st_nxt.fifo.tx_trig = req.wdata[5:4];
                    end
                end
                SEL_ENH_FN: begin
                    st_nxt.enh_fn = urd_enh_fn_t'(req.wdata);
                    if (!req.wdata[4]) begin
                        // Dropping enhanced mode clears the gated bits so they read 0
                        st_nxt.int_en = urd_int_en_t'(st_r.int_en & ~INT_EN_ENH_MASK);
                        st_nxt.fifo.tx_trig = 2'h0;
                        st_nxt.modem_ctl = urd_modem_ctl_t'(st_r.modem_ctl &
                            ~MODEM_ENH_MASK);
                    end
                end
                SEL_LINE_CTL: begin
                    st_nxt.line_ctl = urd_line_ctl_t'(req.wdata);
                end
                SEL_MODEM_CTL: begin
                    st_nxt.modem_ctl = urd_modem_ctl_t'(merge(st_r.modem_ctl,
                        req.wdata, enh_on ? 8'hff : ~MODEM_ENH_MASK));
                end
                SEL_RESUME_ONE: begin
                    st_nxt.resume_one = req.wdata;
                end
                SEL_RESUME_TWO: begin
                    st_nxt.resume_two = req.wdata;
                end
                SEL_STOP_ONE: begin
                    st_nxt.stop_one = req.wdata;
                end
                SEL_STOP_TWO: begin
                    st_nxt.stop_two = req.wdata;
                end
                SEL_HALT: begin
                    st_nxt.halt_resume = urd_halt_t'(req.wdata);
                end
                SEL_TRIG: begin
                    st_nxt.trig = urd_trig_t'(req.wdata);
                end
                SEL_SCRATCH: begin
                    st_nxt.scratch = req.wdata;
                end
                SEL_PIN_DIR: begin
                    st_nxt.pin_dir = req.wdata;
                end
                SEL_PIN_STATE: begin
                    st_nxt.pin_out = req.wdata;
                end
                SEL_PIN_IE: begin
                    st_nxt.pin_ie = req.wdata;
                end
                SEL_PIN_CTL: begin
                    st_nxt.pin_ctl = req.wdata & PIN_CTL_MASK;
                end
                SEL_EXTRA: begin
                    st_nxt.extra = urd_extra_t'(req.wdata & EXTRA_MASK);
                end
                default: begin
                    // Read-only and reserved places keep every stored bit
                    st_nxt = st_r;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.line_ctl <= urd_line_ctl_t'(RESET_VAL);
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Read answer and side effects
    // ****************************************
    always_comb begin
        rdata_nxt = 8'h00;
        rvalid_nxt = req.rd;
        evt_nxt = '0;
        if (req.rd) begin
            case (sel)
                SEL_HOLD: begin
                    rdata_nxt = stat.rx_hold;
                    evt_nxt.rx_take = 1'b1;
                end
                SEL_DIV_LO: begin
                    rdata_nxt = st_r.div_lo;
                end
                SEL_DIV_HI: begin
                    rdata_nxt = st_r.div_hi;
                end
                SEL_DIV_FRAC: begin
                    rdata_nxt = st_r.div_frac;
                end
                SEL_INT_EN: begin
                    rdata_nxt = st_r.int_en;
                end
                SEL_FIFO: begin
                    rdata_nxt = {st_r.fifo.en, st_r.fifo.en, stat.int_src &
                        (enh_on ? 6'h3f : ~SRC_ENH_MASK)};
                    evt_nxt.src_rd = 1'b1;
                end
                SEL_ENH_FN: begin
                    rdata_nxt = st_r.enh_fn;
                end
                SEL_LINE_CTL: begin
                    rdata_nxt = st_r.line_ctl;
                end
                SEL_MODEM_CTL: begin
                    rdata_nxt = st_r.modem_ctl;
                end
                SEL_RESUME_ONE: begin
                    rdata_nxt = st_r.resume_one;
                end
                SEL_RESUME_TWO: begin
                    rdata_nxt = st_r.resume_two;
                end
                SEL_STOP_ONE: begin
                    rdata_nxt = st_r.stop_one;
                end
                SEL_STOP_TWO: begin
                    rdata_nxt = st_r.stop_two;
                end
                SEL_LINE_STAT: begin
                    rdata_nxt = stat.line_stat;
                    evt_nxt.line_rd = 1'b1;
                end
                SEL_MODEM_STAT: begin
                    rdata_nxt = stat.modem_stat;
                    evt_nxt.modem_rd = 1'b1;
                end
                SEL_HALT: begin
                    rdata_nxt = st_r.halt_resume;
                end
                SEL_TRIG: begin
                    rdata_nxt = st_r.trig;
                end
                SEL_SCRATCH: begin
                    rdata_nxt = st_r.scratch;
                end
                SEL_TX_FILL: begin
                    rdata_nxt = {1'b0, stat.tx_fill};
                end
                SEL_RX_FILL: begin
                    rdata_nxt = {1'b0, stat.rx_fill};
                end
                SEL_PIN_DIR: begin
                    rdata_nxt = st_r.pin_dir;
                end
                SEL_PIN_STATE: begin
                    // Reads return pin levels, not the output latch
                    rdata_nxt = stat.pin_in;
                end
                SEL_PIN_IE: begin
                    rdata_nxt = st_r.pin_ie;
                end
                SEL_PIN_CTL: begin
                    rdata_nxt = st_r.pin_ctl;
                end
                SEL_EXTRA: begin
                    rdata_nxt = st_r.extra;
                end
                default: begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
        if (req.wr) begin
            case (sel)
                SEL_HOLD: begin
                    evt_nxt.tx_load = 1'b1;
                    evt_nxt.tx_data = req.wdata;
                end
                SEL_FIFO: begin
                    evt_nxt.rx_fifo_rst = req.wdata[FIFO_RX_RST_BIT];
                    evt_nxt.tx_fifo_rst = req.wdata[FIFO_TX_RST_BIT];
                end
                SEL_PIN_CTL: begin
                    evt_nxt.soft_reset = req.wdata[PIN_CTL_RESET_BIT];
                end
                default: begin
                    evt_nxt.tx_load = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
            evt_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            evt_r <= evt_nxt;
        end
    end

    assign cfg = st_r;
    assign rdata = rdata_r;
    assign rvalid = rvalid_r;
    assign evt = evt_r;
endmodule
`default_nettype wire

// ---- pkg/urd_pkg.sv ----
// Offsets, field layouts and decode targets of the serial port register map.
// Assumes one register access per request, 4-bit offsets, 8-bit data.
package urd_pkg;
    // ****************************************
    // Offsets and constants
    // ****************************************
    localparam logic [3:0] OFS_HOLD = 4'h0;
    localparam logic [3:0] OFS_INT_EN = 4'h1;
    localparam logic [3:0] OFS_FIFO = 4'h2;
    localparam logic [3:0] OFS_LINE_CTL = 4'h3;
    localparam logic [3:0] OFS_MODEM_CTL = 4'h4;
    localparam logic [3:0] OFS_LINE_STAT = 4'h5;
    localparam logic [3:0] OFS_MODEM_STAT = 4'h6;
    localparam logic [3:0] OFS_SCRATCH = 4'h7;
    localparam logic [3:0] OFS_TX_FILL = 4'h8;
    localparam logic [3:0] OFS_RX_FILL = 4'h9;
    localparam logic [3:0] OFS_PIN_DIR = 4'ha;
    localparam logic [3:0] OFS_PIN_STATE = 4'hb;
    localparam logic [3:0] OFS_PIN_IE = 4'hc;
    localparam logic [3:0] OFS_RSVD = 4'hd;
    localparam logic [3:0] OFS_PIN_CTL = 4'he;
    localparam logic [3:0] OFS_EXTRA = 4'hf;
    localparam logic [7:0] ENH_BANK_KEY = 8'hbf;
    localparam logic [7:0] RESET_VAL = 8'h00;
    localparam logic [7:0] INT_EN_ENH_MASK = 8'hf0;
    localparam logic [5:0] SRC_ENH_MASK = 6'h30;
    localparam logic [7:0] MODEM_ENH_MASK = 8'he0;
    localparam logic [7:0] PIN_CTL_MASK = 8'h07;
    localparam logic [7:0] EXTRA_MASK = 8'hb7;
    localparam int FIFO_EN_BIT = 0;
    localparam int FIFO_RX_RST_BIT = 1;
    localparam int FIFO_TX_RST_BIT = 2;
    localparam int PIN_CTL_RESET_BIT = 3;
    // ****************************************
    // Field layouts, most significant first
    // ****************************************
    typedef struct packed {
        logic cts, rts, stop_flow, sleep, modem, rx_line, tx_empty, rx_data;
    } urd_int_en_t;
    typedef struct packed {
        logic div_en, tx_break, force_par, even_par, par_en, stop_bits;
        logic [1:0] word_len;
    } urd_line_ctl_t;
    typedef struct packed {
        logic prescale, infrared, any_char_resume, loopback;
        logic internal_output_two, internal_output_one, rts_out, dtr_out;
    } urd_modem_ctl_t;
    typedef struct packed {
        logic fifo_err, tx_all_empty, tx_hold_empty, rx_break;
        logic rx_framing, rx_parity, rx_overrun, rx_ready;
    } urd_line_stat_t;
    typedef struct packed {
        logic cd, ri, dsr, cts, d_cd, d_ri, d_dsr, d_cts;
    } urd_modem_stat_t;
    typedef struct packed {logic [3:0] resume, halt;} urd_halt_t;
    typedef struct packed {logic [3:0] rx_trig, tx_trig;} urd_trig_t;
    typedef struct packed {
        logic auto_cts, auto_rts, special_char, enh_en;
        logic [3:0] sw_flow;
    } urd_enh_fn_t;
    typedef struct packed {
        logic fast_ir, rsv6, rs485_inv, rs485_en, rsv3, tx_dis, rx_dis, nine_bit;
    } urd_extra_t;
    typedef struct packed {logic [1:0] rx_trig, tx_trig; logic en;} urd_fifo_t;
    typedef struct packed {
        logic [7:0] div_lo, div_hi, div_frac, scratch;
        logic [7:0] resume_one, resume_two, stop_one, stop_two;
        logic [7:0] pin_dir, pin_out, pin_ie, pin_ctl;
        urd_int_en_t int_en;
        urd_fifo_t fifo;
        urd_line_ctl_t line_ctl;
        urd_modem_ctl_t modem_ctl;
        urd_enh_fn_t enh_fn;
        urd_halt_t halt_resume;
        urd_trig_t trig;
        urd_extra_t extra;
    } urd_cfg_t;
    typedef struct packed {
        logic wr, rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } urd_req_t;
    typedef struct packed {
        logic [7:0] rx_hold;
        logic [5:0] int_src;
        urd_line_stat_t line_stat;
        urd_modem_stat_t modem_stat;
        logic [6:0] tx_fill, rx_fill;
        logic [7:0] pin_in;
    } urd_stat_t;
    typedef struct packed {
        logic tx_load;
        logic [7:0] tx_data;
        logic rx_take, src_rd, line_rd, modem_rd;
        logic rx_fifo_rst, tx_fifo_rst, soft_reset;
    } urd_evt_t;
    typedef enum logic [4:0] {
        SEL_NONE = 5'b00000, SEL_HOLD = 5'b00001, SEL_DIV_LO = 5'b00010,
        SEL_DIV_HI = 5'b00011, SEL_INT_EN = 5'b00100, SEL_DIV_FRAC = 5'b00101,
        SEL_FIFO = 5'b00110, SEL_ENH_FN = 5'b00111, SEL_LINE_CTL = 5'b01000,
        SEL_MODEM_CTL = 5'b01001, SEL_RESUME_ONE = 5'b01010,
        SEL_LINE_STAT = 5'b01011, SEL_RESUME_TWO = 5'b01100,
        SEL_MODEM_STAT = 5'b01101, SEL_HALT = 5'b01110, SEL_STOP_ONE = 5'b01111,
        SEL_SCRATCH = 5'b10000, SEL_TRIG = 5'b10001, SEL_STOP_TWO = 5'b10010,
        SEL_TX_FILL = 5'b10011, SEL_RX_FILL = 5'b10100, SEL_PIN_DIR = 5'b10101,
        SEL_PIN_STATE = 5'b10110, SEL_PIN_IE = 5'b10111, SEL_RSVD = 5'b11000,
        SEL_PIN_CTL = 5'b11001, SEL_EXTRA = 5'b11010
    } urd_sel_t;
endpackage

// ---- test/tb.sv ----
// Self-checking bench for the serial port register map.
// Assumes urd_top, urd_far_model and urd_monitor are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module tb
    import urd_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    urd_req_t req = '0;
    urd_stat_t stat;
    urd_cfg_t cfg;
    logic [7:0] rdata;
    logic rvalid;
    urd_evt_t evt;
    logic [7:0] last_tx;
    logic [7:0] n_rst_evt;
    int n_errors = 0;
    int tests_run = 0;
    always #10 sys_clk = ~sys_clk;
    urd_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .stat(stat), .cfg(cfg),
        .rdata(rdata), .rvalid(rvalid), .evt(evt));
    urd_far_model far (.sys_clk(sys_clk), .rst_n(rst_n), .evt(evt), .stat(stat),
        .last_tx(last_tx), .n_rst_evt(n_rst_evt));
    // ****************************************
    // Access tasks
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(posedge sys_clk);
        #1;
        req.wr = 1'b0;
    endtask
    // Answer stands one cycle only, so it is sampled right after the taking edge
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        #1;
        req.rd = 1'b1;
        req.addr = a;
        @(posedge sys_clk);
        #1;
        req.rd = 1'b0;
        chk({7'h00, rvalid}, 8'h01);
        chk(rdata, e);
    endtask
    task automatic wrd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
        wr(a, d);
        rd(a, e);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (2) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        rd(4'h3, 8'h00);
        rd(4'h1, 8'h00);
        $display("test reset done");
        wrd(4'h3, 8'h03, 8'h03);
        wr(4'h0, 8'h5a);
        rd(4'h0, 8'ha5);
        chk(last_tx, 8'h5a);
        rd(4'h5, 8'h61);
        rd(4'h6, 8'hc3);
        rd(4'h8, 8'h40);
        rd(4'h9, 8'h15);
        rd(4'hd, 8'h00);
        wr(4'h5, 8'hff);
        rd(4'h3, 8'h03);
        wr(4'h2, 8'h07);
        rd(4'h2, 8'hcf);
        chk(n_rst_evt, 8'h02);
        $display("test base map done");
        wr(4'h3, 8'h83);
        wrd(4'h0, 8'h12, 8'h12);
        wrd(4'h1, 8'h34, 8'h34);
        wrd(4'h2, 8'h56, 8'h00);
        chk(last_tx, 8'h5a);
        $display("test divisor done");
        wr(4'h3, 8'hbf);
        wrd(4'h2, 8'h10, 8'h10);
        for (int i = 4; i < 8; i++) begin
            wrd(4'(i), 8'(8'h11 * (i - 3)), 8'(8'h11 * (i - 3)));
        end
        wr(4'h3, 8'h83);
        wrd(4'h2, 8'h56, 8'h56);
        $display("test key bank done");
        wr(4'h3, 8'h03);
        wrd(4'h1, 8'hff, 8'hff);
        wrd(4'h4, 8'he3, 8'he3);
        rd(4'h2, 8'hff);
        wr(4'h3, 8'hbf);
        wr(4'h2, 8'h00);
        wr(4'h3, 8'h03);
        rd(4'h1, 8'h0f);
        rd(4'h4, 8'h03);
        wrd(4'h1, 8'hff, 8'h0f);
        rd(4'h2, 8'hcf);
        $display("test enhanced bits done");
        wr(4'h4, 8'h04);
        wrd(4'h6, 8'ha5, 8'ha5);
        wrd(4'h7, 8'h3c, 8'h3c);
        wr(4'h4, 8'h00);
        rd(4'h6, 8'hc3);
        wrd(4'h7, 8'h99, 8'h99);
        wr(4'h4, 8'h04);
        rd(4'h7, 8'h3c);
        $display("test level registers done");
        wrd(4'ha, 8'h5a, 8'h5a);
        wrd(4'hc, 8'h66, 8'h66);
        wr(4'hb, 8'h3c);
        chk(cfg.pin_out, 8'h3c);
        rd(4'hb, 8'h9c);
        wrd(4'he, 8'hff, 8'h07);
        wrd(4'hf, 8'hff, 8'hb7);
        wrd(4'hf, 8'h00, 8'h00);
        $display("test pins and extras done");
        complete_run();
    end
    // About 150 cycles of traffic expected; over thirty times that is a hang
    initial begin
        #100000;
        n_errors++;
        complete_run();
    end
endmodule
bind urd_top urd_monitor mon (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .stat(stat),
    .cfg(cfg), .rdata(rdata), .rvalid(rvalid), .evt(evt));
`default_nettype wire

// ---- test/urd_far_model.sv ----
// Model of the receiver, interrupt, modem and FIFO logic around the register map.
// Assumes fixed status levels; counts the FIFO reset pulses the map hands out and keeps the last transmit byte.
`timescale 1ns/100ps
`default_nettype none
module urd_far_model
    import urd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire urd_evt_t evt,
    output var urd_stat_t stat,
    output var logic [7:0] last_tx,
    output var logic [7:0] n_rst_evt
);
    // Fixed levels keep expected read data simple; each field differs from the others
    always_comb begin
        stat.rx_hold = 8'ha5;
        stat.int_src = 6'h3f;
        stat.line_stat = 8'h61;
        stat.modem_stat = 8'hc3;
        stat.tx_fill = 7'h40;
        stat.rx_fill = 7'h15;
        stat.pin_in = 8'h9c;
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_tx <= 8'h00;
            n_rst_evt <= 8'h00;
        end else begin
            if (evt.tx_load) begin
                last_tx <= evt.tx_data;
            end
            n_rst_evt <= n_rst_evt + 8'(evt.rx_fifo_rst) + 8'(evt.tx_fifo_rst);
        end
    end
endmodule
`default_nettype wire

// ---- test/urd_monitor.sv ----
// Concurrent checks on the register port of the serial port register map.
// Assumes it is bound to urd_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module urd_monitor
    import urd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire urd_req_t req,
    input wire urd_stat_t stat,
    input wire urd_cfg_t cfg,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    input wire urd_evt_t evt
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // ****************************************
    // Assertions
    // ****************************************
    AST_RVALID: assert property (req.rd |=> rvalid)
        else $error("read answer missing");
    AST_IDLE: assert property (!rvalid |-> rdata == 8'h00)
        else $error("read data not zero while idle");
    AST_TX_LOAD: assert property ((req.wr && req.addr == 4'h0 && !cfg.line_ctl.div_en)
        |=> evt.tx_load && evt.tx_data == $past(req.wdata))
        else $error("transmit byte not handed on");
    AST_RX_READ: assert property ((req.rd && req.addr == 4'h0 && !cfg.line_ctl.div_en)
        |=> evt.rx_take && rdata == $past(stat.rx_hold))
        else $error("receive byte read wrong");
    AST_DIV_WR: assert property ((req.wr && req.addr == 4'h0 && cfg.line_ctl.div_en)
        |=> !evt.tx_load && cfg.div_lo == $past(req.wdata))
        else $error("divisor low write wrong");
    AST_LINE_WR: assert property ((req.wr && req.addr == 4'h3)
        |=> cfg.line_ctl == $past(req.wdata))
        else $error("line control write lost");
    AST_LINE_STAT: assert property ((req.rd && req.addr == 4'h5 && cfg.line_ctl != 8'hbf)
        |=> evt.line_rd && rdata == $past(stat.line_stat))
        else $error("line status read wrong");
    AST_FILL: assert property ((req.rd && req.addr == 4'h8)
        |=> rdata == {1'b0, $past(stat.tx_fill)})
        else $error("transmit fill read wrong");
    AST_RSVD: assert property ((req.rd && req.addr == 4'hd) |=> rdata == 8'h00)
        else $error("reserved slot not zero");
    AST_ENH_BITS: assert property (!cfg.enh_fn.enh_en
        |-> cfg.int_en[7:4] == 4'h0 && cfg.modem_ctl[7:5] == 3'h0)
        else $error("enhanced bits held while disabled");
    AST_SRC_RD: assert property ((req.rd && req.addr == 4'h2 && !cfg.line_ctl.div_en)
        |=> evt.src_rd && rdata[7:6] == {2{$past(cfg.fifo.en)}})
        else $error("interrupt status read wrong");
    AST_FRAC_OFF: assert property ((req.rd && req.addr == 4'h2 && cfg.line_ctl.div_en
        && cfg.line_ctl != 8'hbf && !cfg.enh_fn.enh_en) |=> rdata == 8'h00 && !evt.src_rd)
        else $error("fraction answered without enhanced mode");
    AST_MODEM_RD: assert property ((req.rd && req.addr == 4'h6 && !cfg.modem_ctl[2]
        && cfg.line_ctl != 8'hbf) |=> evt.modem_rd && rdata == $past(stat.modem_stat))
        else $error("modem status read wrong");
    AST_SOFT_RST: assert property ((req.wr && req.addr == 4'he)
        |=> evt.soft_reset == $past(req.wdata[3]))
        else $error("soft reset pulse wrong");
    // Main scenarios
    cover property (req.wr && req.addr == 4'h2 && cfg.line_ctl == 8'hbf);
    cover property (req.rd && req.addr == 4'h6 && cfg.modem_ctl[2]);
    cover property (evt.rx_fifo_rst && evt.tx_fifo_rst);
endmodule
`default_nettype wire
